/* core/tag_sec_pkg.sv */
// constants, types and carriers for the tag security command block
`default_nettype none
package tag_sec_pkg;
  // command codes
  localparam logic [7:0] CMD_SET_PWD = 8'hb3;
  localparam logic [7:0] CMD_PROTECT_PAGE = 8'hb6;
  localparam logic [7:0] CMD_LOCK_PAGE = 8'hb7;
  localparam logic [7:0] CMD_KILL = 8'hb9;
  localparam logic [7:0] CMD_PRIVACY = 8'hba;
  // password identifiers
  localparam logic [7:0] PWID_READ = 8'h01;
  localparam logic [7:0] PWID_WRITE = 8'h02;
  localparam logic [7:0] PWID_PRIVACY = 8'h04;
  localparam logic [7:0] PWID_KILL = 8'h08;
  localparam logic [7:0] PWID_EAS = 8'h10;
  // page layout
  localparam logic [7:0] PTR_MAX = 8'h4e;
  localparam logic [6:0] COUNTER_BLOCK = 7'h4f;
  localparam logic [7:0] PROT_MASK = 8'h33;
  localparam int PROT_LOW_READ = 0;
  localparam int PROT_LOW_WRITE = 1;
  localparam int PROT_HIGH_READ = 4;
  localparam int PROT_HIGH_WRITE = 5;
  // error codes
  localparam logic [7:0] ERR_NOT_ADDRESSED = 8'h02;
  localparam logic [7:0] ERR_BAD_ARG = 8'h0f;
  localparam logic [7:0] ERR_NO_ACCESS = 8'h11;
  localparam logic [7:0] ERR_LOCKED = 8'h12;
  // register map, byte addresses
  localparam logic [4:0] REG_PWD_READ = 5'h00;
  localparam logic [4:0] REG_PWD_WRITE = 5'h04;
  localparam logic [4:0] REG_PWD_PRIVACY = 5'h08;
  localparam logic [4:0] REG_PWD_KILL = 5'h0c;
  localparam logic [4:0] REG_PWD_EAS = 5'h10;
  localparam logic [4:0] REG_MODE = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  // timing
  localparam int MCLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 20000;
  localparam int WRITE_DELAY_CYCLES = (WRITE_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // reset values
  localparam logic [31:0] PWD_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_IDLE = 3'b010,
    ST_WAIT = 3'b100
  } fsm_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic addressed;
    logic [7:0] arg0;
    logic [7:0] arg1;
    logic [31:0] pwd;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [7:0] err_code;
  } rsp_t;

  typedef struct packed {
    logic [7:0] pointer;
    logic [7:0] prot;
    logic locked;
    logic killed;
    logic mode64;
  } nv_image_t;
endpackage : tag_sec_pkg
`default_nettype wire

/* core/page_protect_and_privacy_cmds.sv */
// page protection, lock, kill and privacy command handling of the tag
//
// Function
// R1 - command B6h stores page split pointer and both pages' access bits
// R2 - blocks below pointer are low page; pointer block starts high page
// R3 - pointer zero puts blocks 0 to 78 all in the high page
// R4 - pointer accepted only 0x00..0x4E; counter block 79 never page protected
// R5 - pointer or access bits change only with read and write passwords verified
// R6 - no change to pointer or access bits once locked
// R7 - request carries 8-bit pointer then 8-bit status byte after optional UID
// R8 - status b1 low page read protect, b2 low page write protect
// R9 - b5 high read, b6 high write; b3, b4, b7, b8 stored as zero
// R10 - 32-bit mode: 01 read pw both, 10 write pw writes, 11 read/both
// R11 - 64-bit mode: any protected access needs read and write passwords
// R12 - all four commands answer after the write delay
// R13 - failure answers flags, error code, CRC; success flags and CRC only
// R14 - stored pointer and access bits readable for extended info command
// R15 - command B7h permanently locks page settings given both passwords
// R16 - lock request pointer differing from stored one gets error, no lock
// R17 - B9h with correct kill password disables the tag for ever
// R18 - kill only when addressed or selected, otherwise rejected
// R19 - password field equals password xor {rn, rn} of last random number
// R20 - BAh with correct privacy password enters quiet mode
// R21 - privacy password via set password leaves quiet mode
// R22 - password ids: 01 read, 02 write, 04 privacy, 08 kill, 10 EAS/AFI
// R23 - after a wrong password all commands ignored until power-on reset
// R24 - 64-bit mode needs both passwords for protected page access
// R25 - each block access picks page by pointer, then applies page bits
//
// Our own choices: the plain strobed port and the register offsets.
`default_nettype none
module page_protect_and_privacy_cmds
  import tag_sec_pkg::*;
#(
  parameter int WRITE_DELAY_CYC = WRITE_DELAY_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // decoded command from the frame layer
  input wire cmd_req_t CMD,
  input wire logic RN_VALID,
  input wire logic [15:0] RN_VALUE,
  // reply towards the frame layer
  output rsp_t RSP,
  // block access check
  input wire logic ACC_REQ,
  input wire logic [6:0] ACC_BLOCK,
  input wire logic ACC_WRITE,
  output logic ACC_GRANT,
  // tag state
  output logic TAG_ENABLE,
  output logic PRIVACY,
  // nonvolatile image
  input wire nv_image_t NV_LOAD,
  output nv_image_t NV_IMAGE,
  output logic NV_STORE,
  // register port
  input wire logic [4:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WE,
  input wire logic REG_RE,
  output logic [31:0] REG_RDATA
);

  initial begin
    if (WRITE_DELAY_CYC < 1 || WRITE_DELAY_CYC > 65535) begin
      $error("WRITE_DELAY_CYC out of range");
    end
    // pointer range must stop short of the counter block
    if (PTR_MAX >= {1'b0, COUNTER_BLOCK}) begin
      $error("PTR_MAX overlaps the counter block");
    end
  end

  localparam logic [15:0] DELAY_LAST = 16'(WRITE_DELAY_CYC - 1);

  typedef struct packed {
    fsm_t fsm;
    logic [15:0] cnt;
    logic pend_error;
    logic [7:0] pend_code;
    logic pend_reply;
    rsp_t rsp;
    nv_image_t nv;
    logic nv_store;
    logic [15:0] rn;
    logic rn_ok;
    logic read_ok;
    logic write_ok;
    logic eas_ok;
    logic privacy;
    logic muted;
    logic acc_grant;
    logic [31:0] pwd_read;
    logic [31:0] pwd_write;
    logic [31:0] pwd_privacy;
    logic [31:0] pwd_kill;
    logic [31:0] pwd_eas;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // release reset through two flops, assertion stays asynchronous
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [31:0] expected_pwd(input logic [31:0] pw, input logic [15:0] rn);
    expected_pwd = pw ^ {rn, rn}; // R19
  endfunction : expected_pwd

  // known password identifiers; anything else is a bad argument
  function automatic logic pwid_known(input logic [7:0] id);
    unique case (id) // R22
      PWID_READ,
      PWID_WRITE,
      PWID_PRIVACY,
      PWID_KILL,
      PWID_EAS: pwid_known = 1'b1;
      default: pwid_known = 1'b0;
    endcase
  endfunction : pwid_known

  // grant for one page given its write/read bit pair
  function automatic logic page_grant(input logic wbit, input logic rbit, input logic is_wr,
                                      input logic m64, input logic rok, input logic wok);
    logic both;
    both = rok & wok;
    page_grant = 1'b1;
    if (m64) begin
      if (is_wr && (wbit || rbit)) begin
        page_grant = both; // R11 R24
      end else if (!is_wr && rbit) begin
        page_grant = both; // R11 R24
      end
    end else begin
      unique case ({wbit, rbit}) // R10
        2'b01: page_grant = rok;
        2'b10: page_grant = is_wr ? wok : 1'b1;
        2'b11: page_grant = is_wr ? both : rok;
        default: page_grant = 1'b1;
      endcase
    end
  endfunction : page_grant

  always_comb begin
    logic high_page;
    logic [31:0] pw_sel;
    logic pw_known;
    logic pw_match;
    logic both_ok;
    high_page = 1'b0;
    pw_sel = PWD_RESET;
    pw_known = 1'b1;
    pw_match = 1'b0;
    both_ok = s_q.read_ok & s_q.write_ok;
    s_d = s_q;
    s_d.rsp = '0;
    s_d.nv_store = 1'b0;

    // random number from the request handler; only the latest counts
    if (RN_VALID && !s_q.nv.killed && !s_q.muted) begin
      s_d.rn = RN_VALUE; // R19
      s_d.rn_ok = 1'b1;
    end

    // block access check, answered one cycle after the request
    // pointer 0 makes every block >= 0 high page, so no special case needed
    high_page = {1'b0, ACC_BLOCK} >= s_q.nv.pointer; // R2 R3 R25
    if (!ACC_REQ || s_q.nv.killed || s_q.muted) begin
      s_d.acc_grant = 1'b0;
    end else if (ACC_BLOCK == COUNTER_BLOCK) begin
      s_d.acc_grant = 1'b1; // R4
    end else if (high_page) begin
      s_d.acc_grant = page_grant(s_q.nv.prot[PROT_HIGH_WRITE], s_q.nv.prot[PROT_HIGH_READ],
                                 ACC_WRITE, s_q.nv.mode64, s_q.read_ok, s_q.write_ok); // R25
    end else begin
      s_d.acc_grant = page_grant(s_q.nv.prot[PROT_LOW_WRITE], s_q.nv.prot[PROT_LOW_READ],
                                 ACC_WRITE, s_q.nv.mode64, s_q.read_ok, s_q.write_ok); // R25
    end

    // register port; passwords are write-only so they never leak
    s_d.rdata = '0;
    if (REG_WE) begin
      unique case (REG_ADDR)
        REG_PWD_READ: s_d.pwd_read = REG_WDATA;
        REG_PWD_WRITE: s_d.pwd_write = REG_WDATA;
        REG_PWD_PRIVACY: s_d.pwd_privacy = REG_WDATA;
        REG_PWD_KILL: s_d.pwd_kill = REG_WDATA;
        REG_PWD_EAS: s_d.pwd_eas = REG_WDATA;
        REG_MODE: begin
          // one-way switch: 64-bit mode cannot be left
          if (REG_WDATA[0] && !s_q.nv.mode64) begin
            s_d.nv.mode64 = 1'b1;
            s_d.nv_store = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (REG_RE) begin
      unique case (REG_ADDR)
        REG_MODE: s_d.rdata = {31'h0000_0000, s_q.nv.mode64};
        REG_STATUS: s_d.rdata = {7'h00,
                                 s_q.rn_ok, s_q.eas_ok,
                                 s_q.write_ok, s_q.read_ok,
                                 s_q.muted, s_q.privacy,
                                 s_q.nv.mode64, s_q.nv.killed, s_q.nv.locked,
                                 s_q.nv.prot,
                                 s_q.nv.pointer};
        default: s_d.rdata = '0;
      endcase
    end

    // password selection for set password
    unique case (CMD.arg0) // R22
      PWID_READ: pw_sel = s_q.pwd_read;
      PWID_WRITE: pw_sel = s_q.pwd_write;
      PWID_PRIVACY: pw_sel = s_q.pwd_privacy;
      PWID_KILL: pw_sel = s_q.pwd_kill;
      PWID_EAS: pw_sel = s_q.pwd_eas;
      default: pw_sel = PWD_RESET;
    endcase
    pw_known = pwid_known(CMD.arg0); // R22

    unique case (s_q.fsm)
      ST_LOAD: begin
        // nonvolatile settings captured once after reset release
        s_d.nv = NV_LOAD;
        s_d.fsm = ST_IDLE;
      end
      ST_IDLE: begin
        s_d.pend_error = 1'b0;
        s_d.pend_code = '0;
        s_d.pend_reply = 1'b0;
        // killed or muted tags take no new commands; quiet mode only hears set password
        if (CMD.valid && !s_q.nv.killed && !s_q.muted // R17 R23
            && (!s_q.privacy || CMD.code == CMD_SET_PWD)) begin // R20
          unique case (CMD.code)
            CMD_SET_PWD: begin
              pw_match = s_q.rn_ok && pw_known && CMD.pwd == expected_pwd(pw_sel, s_q.rn);
              if (!CMD.addressed && CMD.arg0 != PWID_PRIVACY) begin
                s_d.pend_reply = 1'b1;
                s_d.pend_error = 1'b1;
                s_d.pend_code = ERR_NOT_ADDRESSED;
              end else if (!pw_known) begin
                s_d.pend_reply = 1'b1;
                s_d.pend_error = 1'b1;
                s_d.pend_code = ERR_BAD_ARG;
              end else if (!pw_match) begin
                s_d.muted = 1'b1; // R23
              end else begin
                s_d.pend_reply = 1'b1;
                // verified flags live until power-on reset only
                if (CMD.arg0 == PWID_READ) begin
                  s_d.read_ok = 1'b1;
                end
                if (CMD.arg0 == PWID_WRITE) begin
                  s_d.write_ok = 1'b1;
                end
                if (CMD.arg0 == PWID_EAS) begin
                  s_d.eas_ok = 1'b1;
                end
                if (CMD.arg0 == PWID_PRIVACY) begin
                  s_d.privacy = 1'b0; // R21
                end
              end
            end
            CMD_PROTECT_PAGE: begin
              s_d.pend_reply = 1'b1;
              if (!both_ok) begin
                s_d.pend_error = 1'b1; // R5
                s_d.pend_code = ERR_NO_ACCESS;
              end else if (s_q.nv.locked) begin
                s_d.pend_error = 1'b1; // R6
                s_d.pend_code = ERR_LOCKED;
              end else if (CMD.arg0 > PTR_MAX) begin
                s_d.pend_error = 1'b1; // R4
                s_d.pend_code = ERR_BAD_ARG;
              end else begin
                s_d.nv.pointer = CMD.arg0; // R1 R7
                s_d.nv.prot = CMD.arg1 & PROT_MASK; // R8 R9
                s_d.nv_store = 1'b1;
              end
            end
            CMD_LOCK_PAGE: begin
              s_d.pend_reply = 1'b1;
              if (!both_ok) begin
                s_d.pend_error = 1'b1; // R15
                s_d.pend_code = ERR_NO_ACCESS;
              end else if (CMD.arg0 != s_q.nv.pointer) begin
                s_d.pend_error = 1'b1; // R16
                s_d.pend_code = ERR_BAD_ARG;
              end else begin
                s_d.nv.locked = 1'b1; // R15
                s_d.nv_store = 1'b1;
              end
            end
            CMD_KILL: begin
              if (!CMD.addressed) begin
                s_d.pend_reply = 1'b1; // R18
                s_d.pend_error = 1'b1;
                s_d.pend_code = ERR_NOT_ADDRESSED;
              end else if (s_q.rn_ok && CMD.pwd == expected_pwd(s_q.pwd_kill, s_q.rn)) begin
                // this one reply still goes out, nothing after it
                s_d.pend_reply = 1'b1;
                s_d.nv.killed = 1'b1; // R17
                s_d.nv_store = 1'b1;
              end else begin
                s_d.muted = 1'b1; // R23
              end
            end
            CMD_PRIVACY: begin
              if (s_q.rn_ok && CMD.pwd == expected_pwd(s_q.pwd_privacy, s_q.rn)) begin
                s_d.pend_reply = 1'b1;
                s_d.privacy = 1'b1; // R20
              end else begin
                s_d.muted = 1'b1; // R23
              end
            end
            default: ;
          endcase
          if (s_d.pend_reply) begin
            s_d.fsm = ST_WAIT; // R12
            s_d.cnt = DELAY_LAST;
          end
        end
      end
      ST_WAIT: begin
        // the reader waits out the write delay, so requests here are dropped
        if (s_q.cnt == 16'h0000) begin
          s_d.rsp.valid = 1'b1; // R12
          s_d.rsp.error = s_q.pend_error; // R13
          s_d.rsp.err_code = s_q.pend_error ? s_q.pend_code : 8'h00; // R13
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      // power-on reset forgets every verified password and the mute
      s_q <= '{fsm: ST_LOAD,
               pwd_read: PWD_RESET,
               pwd_write: PWD_RESET,
               pwd_privacy: PWD_RESET,
               pwd_kill: PWD_RESET,
               pwd_eas: PWD_RESET,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign RSP = s_q.rsp;
  assign ACC_GRANT = s_q.acc_grant;
  assign TAG_ENABLE = !s_q.nv.killed && !s_q.muted && !s_q.privacy && s_q.fsm == ST_IDLE;
  assign PRIVACY = s_q.privacy;
  assign NV_IMAGE = s_q.nv; // R14
  assign NV_STORE = s_q.nv_store;
  assign REG_RDATA = s_q.rdata;

endmodule : page_protect_and_privacy_cmds
`default_nettype wire

/* bench/page_protect_and_privacy_cmds_properties.sv */
// port checker for the security command block
`default_nettype none
module tag_sec_checker
  import tag_sec_pkg::*;
#(parameter int WRITE_DELAY_CYC = WRITE_DELAY_CYCLES) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // command side
  input wire cmd_req_t CMD,
  input wire rsp_t RSP,
  input wire logic ACC_REQ,
  input wire logic [6:0] ACC_BLOCK,
  input wire logic ACC_GRANT,
  // state and registers
  input wire logic TAG_ENABLE,
  input wire logic PRIVACY,
  input wire nv_image_t NV_IMAGE,
  input wire logic [4:0] REG_ADDR,
  input wire logic REG_RE,
  input wire logic [31:0] REG_RDATA
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  // counts from the taking edge; a counter, since the delay may exceed a plain delay
  int wait_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N)
      wait_q <= 0;
    else if ((wait_q == 0 || wait_q == WRITE_DELAY_CYC + 1) && CMD.valid &&
             (TAG_ENABLE || (PRIVACY && CMD.code == CMD_SET_PWD)))
      wait_q <= 1;
    else if (wait_q != 0)
      wait_q <= (wait_q == WRITE_DELAY_CYC + 1) ? 0 : wait_q + 1;
  end
  property p_reply_time; RSP.valid |-> wait_q == WRITE_DELAY_CYC + 1; endproperty
  a_reply_time: assert property (p_reply_time) else $error("reply off delay");
  property p_pulse; RSP.valid |=> !RSP.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("reply too long");
  property p_code; RSP.valid |-> RSP.error == (RSP.err_code != 8'h00); endproperty
  a_code: assert property (p_code) else $error("reply code");
  property p_no_grant; !ACC_REQ |=> !ACC_GRANT; endproperty
  a_no_grant: assert property (p_no_grant) else $error("grant unasked");
  property p_counter; ACC_REQ && ACC_BLOCK == COUNTER_BLOCK |=> ACC_GRANT; endproperty
  a_counter: assert property (p_counter) else $error("counter block denied");
  property p_public;
    ACC_REQ && ACC_BLOCK != COUNTER_BLOCK && (({1'b0, ACC_BLOCK} >= NV_IMAGE.pointer) ?
      NV_IMAGE.prot[5:4] : NV_IMAGE.prot[1:0]) == 2'b00 |=> ACC_GRANT;
  endproperty
  a_public: assert property (p_public) else $error("public block denied");
  property p_locked;
    $past(NV_IMAGE.locked) |-> NV_IMAGE.locked && $stable(NV_IMAGE.pointer) &&
      $stable(NV_IMAGE.prot);
  endproperty
  a_locked: assert property (p_locked) else $error("locked settings moved");
  property p_killed; $past(NV_IMAGE.killed) |-> NV_IMAGE.killed && !TAG_ENABLE; endproperty
  a_killed: assert property (p_killed) else $error("killed tag woke");
  property p_quiet; PRIVACY |-> !TAG_ENABLE; endproperty
  a_quiet: assert property (p_quiet) else $error("quiet tag enabled");
  property p_info;
    REG_RE && REG_ADDR == REG_STATUS |=>
      REG_RDATA[15:0] == $past({NV_IMAGE.prot, NV_IMAGE.pointer});
  endproperty
  a_info: assert property (p_info) else $error("status readback");
  cover property (RSP.valid && RSP.error);
  cover property ($rose(PRIVACY));
  cover property ($rose(NV_IMAGE.locked));
endmodule : tag_sec_checker
bind page_protect_and_privacy_cmds tag_sec_checker #(.WRITE_DELAY_CYC(WRITE_DELAY_CYC)) chk_u (
  .MCLK(MCLK), .RESET_N(RESET_N), .CMD(CMD), .RSP(RSP), .ACC_REQ(ACC_REQ),
  .ACC_BLOCK(ACC_BLOCK), .ACC_GRANT(ACC_GRANT), .TAG_ENABLE(TAG_ENABLE),
  .PRIVACY(PRIVACY), .NV_IMAGE(NV_IMAGE), .REG_ADDR(REG_ADDR), .REG_RE(REG_RE),
  .REG_RDATA(REG_RDATA));
`default_nettype wire

/* bench/tag_reader_model.sv */
// interrogator model: random numbers and command frames
`default_nettype none
module tag_reader_model
  import tag_sec_pkg::*;
#(parameter int D = 4) (
  // clock
  input wire logic mclk,
  // command link
  output var cmd_req_t cmd,
  output var logic rn_valid,
  output var logic [15:0] rn_value,
  input wire rsp_t rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] rn = 16'h0000;
  initial begin
    cmd = '0;
    rn_valid = 1'b0;
    rn_value = 16'h0000;
  end
  task automatic new_rn(input logic [15:0] v);
    @(posedge mclk);
    rn_valid <= 1'b1;
    rn_value <= v;
    rn = v;
    @(posedge mclk);
    rn_valid <= 1'b0;
    rn_value <= ~v;
  endtask : new_rn
  // plain password in; waits the write delay for a reply, silence allowed
  task automatic send(input logic [7:0] c, a0, a1, input logic adr, input logic [31:0] pw,
      output logic got, output rsp_t r);
    @(posedge mclk);
    cmd <= '{1'b1, c, adr, a0, a1, pw ^ {rn, rn}};
    @(posedge mclk);
    cmd <= {1'b0, ~cmd[$bits(cmd_req_t)-2:0]};
    got = 1'b0;
    r = '0;
    for (int n = 0; n < D + 3 && !got; n++) begin
      @(posedge mclk);
      got = rsp.valid;
      r = rsp;
    end
  endtask : send
endmodule : tag_reader_model
`default_nettype wire

/* bench/page_protect_and_privacy_cmds_tb.sv */
// self-checking bench for the security command block
`default_nettype none
module page_protect_and_privacy_cmds_tb;
  import tag_sec_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int D = 4;
  localparam logic [31:0] PW = 32'ha5a5_0000;
  typedef struct packed {logic [7:0] c, a, b, ec, p, pr;} row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic acc_req = 1'b0;
  logic acc_write = 1'b0;
  logic [6:0] acc_block = 7'h00;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic acc_grant, tag_enable, privacy, rn_valid, nv_store;
  logic [15:0] rn_value;
  logic [31:0] reg_rdata, d;
  cmd_req_t cmd_req;
  rsp_t rsp;
  nv_image_t nv_load = '0;
  nv_image_t nv_image;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  row_t rows [7] = '{'{CMD_PROTECT_PAGE, 8'h14, 8'h33, 8'h00, 8'h14, 8'h33},
    '{CMD_PROTECT_PAGE, 8'h4f, 8'h00, ERR_BAD_ARG, 8'h14, 8'h33},
    '{CMD_PROTECT_PAGE, 8'h4e, 8'hff, 8'h00, 8'h4e, 8'h33},
    '{CMD_PROTECT_PAGE, 8'h00, 8'h12, 8'h00, 8'h00, 8'h12},
    '{CMD_LOCK_PAGE, 8'h05, 8'h00, ERR_BAD_ARG, 8'h00, 8'h12},
    '{CMD_LOCK_PAGE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12},
    '{CMD_PROTECT_PAGE, 8'h14, 8'h00, ERR_LOCKED, 8'h00, 8'h12}};
  // block, write, expected grant; pointer 14, low write and high read protected
  logic [8:0] acc_tab [7] = '{{7'h00, 2'b01}, {7'h00, 2'b10}, {7'h13, 2'b10},
    {7'h14, 2'b00}, {7'h14, 2'b10}, {7'h4e, 2'b00}, {7'h4f, 2'b11}};

  page_protect_and_privacy_cmds #(.WRITE_DELAY_CYC(D)) dut_u (.MCLK(mclk), .RESET_N(reset_n),
    .CMD(cmd_req), .RN_VALID(rn_valid), .RN_VALUE(rn_value), .RSP(rsp), .ACC_REQ(acc_req),
    .ACC_BLOCK(acc_block), .ACC_WRITE(acc_write), .ACC_GRANT(acc_grant),
    .TAG_ENABLE(tag_enable), .PRIVACY(privacy), .NV_LOAD(nv_load), .NV_IMAGE(nv_image),
    .NV_STORE(nv_store), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we),
    .REG_RE(reg_re), .REG_RDATA(reg_rdata));
  tag_reader_model #(.D(D)) rdr_u (.mclk(mclk), .cmd(cmd_req), .rn_valid(rn_valid),
    .rn_value(rn_value), .rsp(rsp));

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask : rd
  task automatic acc(input logic [8:0] t);
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_block <= t[8:2];
    acc_write <= t[1];
    @(posedge mclk);
    acc_req <= 1'b0;
    @(posedge mclk);
    chk(acc_grant, t[0]);
  endtask : acc
  // expected code ff stands for silence
  task automatic cmd(input logic [7:0] c, a0, a1, input logic adr, input logic [31:0] pw,
      input logic [7:0] ec);
    logic got;
    rsp_t r;
    rdr_u.send(c, a0, a1, adr, pw, got, r);
    if (ec === 8'hff)
      chk({got, r}, 0);
    else
      chk({got, r.error, r.err_code}, {1'b1, ec != 8'h00, ec});
  endtask : cmd
  task automatic rst(input nv_image_t nv);
    @(posedge mclk);
    reset_n <= 1'b0;
    nv_load <= nv;
    repeat (12) @(posedge mclk);
    chk({nv_image, rsp}, 0);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(nv_image, nv);
  endtask : rst
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    rst('{8'h14, 8'h00, 1'b0, 1'b0, 1'b0});
    for (int i = 0; i < 4; i++)
      wr(5'(4 * i), PW + i);
    rd(5'h1c, d);
    chk(d, 0);
    rdr_u.new_rn(16'h3c5a);
    cmd(CMD_PROTECT_PAGE, 8'h14, 8'h33, 1'b1, 0, ERR_NO_ACCESS);
    cmd(CMD_SET_PWD, PWID_READ, 0, 1'b1, PW, 0);
    cmd(CMD_SET_PWD, PWID_WRITE, 0, 1'b1, PW + 1, 0);
    for (int i = 0; i < 7; i++) begin
      cmd(rows[i].c, rows[i].a, rows[i].b, 1'b1, 0, rows[i].ec);
      chk({nv_image.pointer, nv_image.prot}, {rows[i].p, rows[i].pr});
    end
    rd(REG_STATUS, d);
    chk(d[16:0], {1'b1, 8'h12, 8'h00});
    $display("page rows done");
    cmd(CMD_PRIVACY, 0, 0, 1'b1, PW + 2, 0);
    chk(privacy, 1);
    cmd(CMD_PROTECT_PAGE, 0, 0, 1'b1, 0, 8'hff);
    rdr_u.new_rn(16'h9e01);
    cmd(CMD_SET_PWD, PWID_PRIVACY, 0, 1'b1, PW + 2, 0);
    chk(privacy, 0);
    cmd(CMD_KILL, 0, 0, 1'b0, PW + 3, ERR_NOT_ADDRESSED);
    cmd(CMD_KILL, 0, 0, 1'b1, PW + 3, 0);
    cmd(CMD_SET_PWD, PWID_READ, 0, 1'b1, PW, 8'hff);
    chk(nv_image.killed, 1);
    $display("privacy and kill done");
    rst('{8'h14, 8'h12, 1'b0, 1'b0, 1'b0});
    for (int i = 0; i < 7; i++)
      acc(acc_tab[i]);
    rdr_u.new_rn(16'h0f0f);
    cmd(CMD_SET_PWD, PWID_READ, 0, 1'b1, PWD_RESET, 0);
    acc({7'h14, 2'b11});
    wr(REG_MODE, 1);
    @(posedge mclk);
    chk(nv_store, 1);
    acc({7'h14, 2'b00});
    cmd(CMD_SET_PWD, PWID_WRITE, 0, 1'b1, 32'h1, 8'hff);
    cmd(CMD_SET_PWD, PWID_WRITE, 0, 1'b1, PWD_RESET, 8'hff);
    rd(REG_STATUS, d);
    chk(d[20], 1);
    $display("access and mute done");
    finish_test();
  end
endmodule : page_protect_and_privacy_cmds_tb
`default_nettype wire
